/* design/t1ai_alarm_irq.sv */
// Receive alarm interrupt status, enables and Avalon-MM register slave.
// Behaviour
// - Excess-zero enable gates change interrupt.
// - Excess-zero enable bit readable, resets zero.
// - Message over 276 bytes sets flag.
// - Over-length flag sticky, cleared on read.
// - Over-length enable read/write, resets zero.
// - Loss declare or clear sets bit 3.
// - Loss change flag cleared on read.
// - Excess-zero change flag cleared on read.
// - Loss change enable active low.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module t1ai_alarm_irq
   import t1ai_pkg::*;
(
   input  wire logic                        CLK,           // Framer clock, 50 MHz.
   input  wire logic                        RST,           // Synchronous reset, active high.
   input  wire logic [t1ai_pkg::ADDR_W-1:0] ADDRESS,       // Avalon byte address.
   input  wire logic                        READ,          // Avalon read request.
   input  wire logic                        WRITE,         // Avalon write request.
   input  wire logic [31:0]                 WRITEDATA,     // Avalon write data.
   input  wire logic [3:0]                  BYTEENABLE,    // Avalon byte enables.
   output logic [31:0]                      READDATA,      // Avalon read data.
   output logic                             WAITREQUEST,   // Avalon wait request.
   input  wire logic                        EXZ_COND,      // Excess-zero condition level.
   input  wire logic                        LOS_COND,      // Receive loss-of-signal level.
   input  wire logic                        DL1_MSG_START, // Pulse: new message begins.
   input  wire logic                        DL1_BYTE_STB,  // Pulse: one message byte taken.
   output logic                             IRQ            // Framer interrupt, active high.
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   t1ai_bus_t           bus_ff;        // Bus handshake state.
   t1ai_bus_t           nxt_bus;       // Next bus state.
   logic                wait_ff;       // Wait request flop.
   logic [31:0]         rdata_ff;      // Read data flop.
   logic                irq_ff;        // Interrupt flop.
   logic                exz_en_ff;     // Excess-zero change enable.
   logic                ovl_en_ff;     // Over-length enable.
   logic                los_en_n_ff;   // Loss change enable, active low.
   logic                exz_prev_ff;   // Excess-zero level, one cycle old.
   logic                los_prev_ff;   // Loss level, one cycle old.
   logic [8:0]          byte_cnt_ff;   // Bytes of the current message.
   logic                ovl_done_ff;   // Over-length already reported this message.
   logic [NUM_SRC-1:0]  evt;           // Event pulse per source.
   logic [NUM_SRC-1:0]  clr;           // Read clear per source.
   logic [NUM_SRC-1:0]  flag;          // Sticky flag per source.
   logic [NUM_SRC-1:0]  en_eff;        // Active-high enable per source.
   logic                req;           // Any request present.
   logic                accept;        // Request completes at this edge.
   logic                first;         // First cycle of a request.
   logic [15:0]         widx;          // Register index from the address.
   logic                wr_lane0;      // Write hitting the low byte.
   logic                hit_exz_en;    // Excess-zero enable selected.
   logic                hit_ovl_en;    // Over-length enable selected.
   logic                hit_los_en;    // Loss enable selected.
   logic                hit_exz_st;    // Excess-zero status selected.
   logic                hit_ovl_st;    // Over-length status selected.
   logic                hit_los_st;    // Loss status selected.
   logic [7:0]          rd_mux;        // Selected register value.
   logic                ovl_evt;       // Byte beyond the legal length.
   logic [8:0]          nxt_cnt;       // Next byte count.

   // ****************************************************************
   // Address decode and read selection.
   // ****************************************************************
   assign req        = READ | WRITE;
   assign first      = req & (bus_ff == BUS_IDLE);
   assign accept     = req & (bus_ff == BUS_DONE);
   assign widx       = {2'h0, ADDRESS[15:2]};
   assign wr_lane0   = WRITE & BYTEENABLE[0] & accept;
   assign hit_exz_en = (ADDRESS[1:0] == 2'h0) && (widx == EXZ_ENABLE_IDX);
   assign hit_ovl_en = (ADDRESS[1:0] == 2'h0) && (widx == OVL_ENABLE_IDX);
   assign hit_los_en = (ADDRESS[1:0] == 2'h0) && (widx == LOS_ENABLE_IDX);
   assign hit_exz_st = (ADDRESS[1:0] == 2'h0) && (widx == EXCESS_ZERO_CHANGE_FLAG_IDX);
   assign hit_ovl_st = (ADDRESS[1:0] == 2'h0) && (widx == OVL_STATUS_IDX);
   assign hit_los_st = (ADDRESS[1:0] == 2'h0) && (widx == LOS_STATUS_IDX);
   // Reserved bits read zero; unmapped addresses read zero.
   assign rd_mux = hit_exz_en ? (8'h00 | (8'(exz_en_ff) << EXZ_BIT)) :
                   hit_ovl_en ? (8'h00 | (8'(ovl_en_ff) << OVL_BIT)) :
                   hit_los_en ? (8'h00 | (8'(los_en_n_ff) << LOS_BIT)) :
                   hit_exz_st ? (8'h00 | (8'(flag[SRC_EXZ]) << EXZ_BIT)) :
                   hit_ovl_st ? (8'h00 | (8'(flag[SRC_OVL]) << OVL_BIT)) :
                   hit_los_st ? (8'h00 | (8'(flag[SRC_LOS]) << LOS_BIT)) :
                   8'h00;

   // A read clears its flags in the cycle the value is captured.
   assign clr[SRC_EXZ] = READ & first & hit_exz_st;
   assign clr[SRC_OVL] = READ & first & hit_ovl_st;
   assign clr[SRC_LOS] = READ & first & hit_los_st;

   // Bus handshake: one wait cycle, then completion.
   assign nxt_bus = first ? BUS_DONE : BUS_IDLE;

   // ****************************************************************
   // Event detection.
   // ****************************************************************
   assign evt[SRC_EXZ] = EXZ_COND ^ exz_prev_ff;
   assign evt[SRC_LOS] = LOS_COND ^ los_prev_ff;
   assign ovl_evt      = DL1_BYTE_STB & ~DL1_MSG_START & ~ovl_done_ff
                         & (byte_cnt_ff == LAPD_MAX_BYTES);
   assign evt[SRC_OVL] = ovl_evt;
   assign nxt_cnt      = DL1_MSG_START ? BYTE_CNT_RST :
                         (DL1_BYTE_STB && byte_cnt_ff != 9'h1ff) ? 9'(byte_cnt_ff + 9'h001) :
                         byte_cnt_ff;
   // Loss enable is stored inverted: zero enables it.
   assign en_eff = {~los_en_n_ff, ovl_en_ff, exz_en_ff};

   // ****************************************************************
   // Sticky flags, one per source.
   // ****************************************************************
   generate
      for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
         t1ai_event_flag u_flag (
            .CLK  (CLK),
            .RST  (RST),
            .EVT  (evt[i]),
            .CLR  (clr[i]),
            .FLAG (flag[i])
         );
      end
   endgenerate

   // ****************************************************************
   // Registers.
   // ****************************************************************
   // Bus handshake and read data.
   always_ff @(posedge CLK) begin
      if (RST) begin
         bus_ff   <= BUS_IDLE;
         wait_ff  <= 1'h1;
         rdata_ff <= 32'h0;
      end else begin
         bus_ff   <= nxt_bus;
         wait_ff  <= ~first;
         rdata_ff <= first ? {24'h0, rd_mux} : rdata_ff;
      end
   end

   // Enable bits written by software.
   always_ff @(posedge CLK) begin
      if (RST) begin
         exz_en_ff   <= EXZ_EN_RST;
         ovl_en_ff   <= OVL_EN_RST;
         los_en_n_ff <= LOS_EN_N_RST;
      end else begin
         if (wr_lane0 && hit_exz_en) begin
            exz_en_ff <= WRITEDATA[EXZ_BIT];
         end
         if (wr_lane0 && hit_ovl_en) begin
            ovl_en_ff <= WRITEDATA[OVL_BIT];
         end
         if (wr_lane0 && hit_los_en) begin
            los_en_n_ff <= WRITEDATA[LOS_BIT];
         end
      end
   end

   // Condition history, byte counter and interrupt output.
   always_ff @(posedge CLK) begin
      if (RST) begin
         exz_prev_ff <= 1'h0;
         los_prev_ff <= 1'h0;
         byte_cnt_ff <= BYTE_CNT_RST;
         ovl_done_ff <= 1'h0;
         irq_ff      <= 1'h0;
      end else begin
         exz_prev_ff <= EXZ_COND;
         los_prev_ff <= LOS_COND;
         byte_cnt_ff <= nxt_cnt;
         ovl_done_ff <= ~DL1_MSG_START & (ovl_done_ff | ovl_evt);
         irq_ff      <= |(flag & en_eff);
      end
   end

   assign READDATA    = rdata_ff;
   assign WAITREQUEST = wait_ff;
   assign IRQ         = irq_ff;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // The flag is set one edge after the change, set winning over any read, and the
   // interrupt follows from the enable in force at that edge.
   property p_exz_irq;
      evt[SRC_EXZ] ##1 exz_en_ff |=> irq_ff;
   endproperty
   a_exz_irq: assert property (p_exz_irq) else $error("Excess-zero change gave no irq.");

   property p_exz_en_rst;
      $rose(exz_en_ff) |-> $past(wr_lane0 && hit_exz_en && WRITEDATA[EXZ_BIT]);
   endproperty
   a_exz_en_rst: assert property (p_exz_en_rst) else $error("Enable rose unwritten.");

   property p_ovl_set;
      (DL1_BYTE_STB && !DL1_MSG_START && !ovl_done_ff && byte_cnt_ff == 9'h114) |=> flag[SRC_OVL];
   endproperty
   a_ovl_set: assert property (p_ovl_set) else $error("Over-length not flagged.");

   property p_ovl_not_early;
      (byte_cnt_ff < 9'h114) |-> !ovl_evt;
   endproperty
   a_ovl_not_early: assert property (p_ovl_not_early) else $error("Over-length too early.");

   property p_ovl_read;
      (clr[SRC_OVL] && !evt[SRC_OVL]) |=> !flag[SRC_OVL] ##1 (READDATA[OVL_BIT] == $past(flag[SRC_OVL], 2));
   endproperty
   a_ovl_read: assert property (p_ovl_read) else $error("Over-length read wrong.");

   property p_ovl_en;
      (wr_lane0 && hit_ovl_en) |=> ovl_en_ff == $past(WRITEDATA[OVL_BIT]);
   endproperty
   a_ovl_en: assert property (p_ovl_en) else $error("Over-length enable not written.");

   property p_los_set;
      (LOS_COND != $past(LOS_COND)) |=> flag[SRC_LOS];
   endproperty
   a_los_set: assert property (p_los_set) else $error("Loss change not flagged.");

   property p_los_read;
      (clr[SRC_LOS] && !evt[SRC_LOS]) |=> !flag[SRC_LOS];
   endproperty
   a_los_read: assert property (p_los_read) else $error("Loss flag not cleared.");

   property p_exz_read;
      (clr[SRC_EXZ] && !evt[SRC_EXZ]) |=> !flag[SRC_EXZ];
   endproperty
   a_exz_read: assert property (p_exz_read) else $error("Excess-zero flag not cleared.");

   property p_los_polarity;
      (flag[SRC_LOS] && los_en_n_ff && !flag[SRC_EXZ] && !flag[SRC_OVL]) |=> !irq_ff;
   endproperty
   a_los_polarity: assert property (p_los_polarity) else $error("Loss enable polarity.");

   property p_irq_match;
      ##1 (irq_ff == $past(|(flag & en_eff)));
   endproperty
   a_irq_match: assert property (p_irq_match) else $error("Interrupt mismatch.");

   property p_wait_one;
      first |=> !wait_ff ##1 wait_ff;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("Bus answer timing.");

   c_ovl_irq: cover property (ovl_evt && ovl_en_ff ##2 irq_ff);
   c_los_irq: cover property (evt[SRC_LOS] && !los_en_n_ff ##2 irq_ff);
   c_set_clr: cover property (evt[SRC_EXZ] && clr[SRC_EXZ]);
   c_read_done: cover property (READ && accept);

endmodule

/* design/t1ai_event_flag.sv */
// Sticky reset-upon-read event flag with set winning over clear.
module t1ai_event_flag
   import t1ai_pkg::*;
(
   input  wire logic CLK,      // Framer clock.
   input  wire logic RST,      // Synchronous reset, active high.
   input  wire logic EVT,      // One-cycle event pulse.
   input  wire logic CLR,      // One-cycle clear from a register read.
   output logic      FLAG      // Sticky flag.
);

   // ****************************************************************
   // Flag storage.
   // ****************************************************************
   logic flag_ff;              // Held flag.
   logic nxt_flag;             // Next flag value.

   // A new event holds the flag even in the cycle that a read clears it.
   assign nxt_flag = EVT | (flag_ff & ~CLR);
   assign FLAG     = flag_ff;

   // Flag register.
   always_ff @(posedge CLK) begin
      if (RST) begin
         flag_ff <= FLAG_RST;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   property p_set_wins;
      @(posedge CLK) disable iff (RST) EVT |=> flag_ff;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Event lost in flag.");

   property p_clear_works;
      @(posedge CLK) disable iff (RST) (CLR && !EVT) |=> !flag_ff;
   endproperty
   a_clear_works: assert property (p_clear_works) else $error("Read did not clear flag.");

endmodule

/* pkg/t1ai_pkg.sv */
// Package of offsets, field positions, reset values and counts for the receive alarm interrupts.
package t1ai_pkg;

   // ****************************************************************
   // Register indices and address width.
   // ****************************************************************
   localparam logic [15:0] EXZ_ENABLE_IDX  = 16'h0b0e; // Excess-zero interrupt enable index.
   localparam logic [15:0] OVL_STATUS_IDX  = 16'h0b11; // Over-length status index.
   localparam logic [15:0] OVL_ENABLE_IDX  = 16'h0b10; // Over-length enable index.
   localparam logic [15:0] LOS_STATUS_IDX  = 16'h0b13; // Loss-of-signal change status index.
   localparam logic [15:0] LOS_ENABLE_IDX  = 16'h0b14; // Loss-of-signal change enable index.
   localparam logic [15:0] EXCESS_ZERO_CHANGE_FLAG_IDX  = 16'h0b0f; // Excess-zero change status index.
   localparam int          ADDR_W          = 16;       // Avalon byte address width.

   // ****************************************************************
   // Field positions and reset values.
   // ****************************************************************
   localparam int          EXZ_BIT         = 0;        // Excess-zero flag and enable bit.
   localparam int          OVL_BIT         = 0;        // Over-length flag and enable bit.
   localparam int          LOS_BIT         = 3;        // Loss-of-signal flag and enable bit.
   localparam logic        EXZ_EN_RST      = 1'h0;     // Excess-zero enable after reset.
   localparam logic        OVL_EN_RST      = 1'h0;     // Over-length enable after reset.
   localparam logic        LOS_EN_N_RST    = 1'h1;     // Loss enable (inverted) after reset.
   localparam logic        FLAG_RST        = 1'h0;     // Every status flag after reset.

   // ****************************************************************
   // Sources and counts.
   // ****************************************************************
   localparam int          NUM_SRC         = 3;        // Event sources: exz, ovl, los.
   localparam int          SRC_EXZ         = 0;        // Source index of excess zeros.
   localparam int          SRC_OVL         = 1;        // Source index of over-length.
   localparam int          SRC_LOS         = 2;        // Source index of loss of signal.
   localparam logic [8:0]  LAPD_MAX_BYTES  = 9'h114;   // Longest legal message, 276 bytes.
   localparam logic [8:0]  BYTE_CNT_RST    = 9'h000;   // Byte counter after reset.

   // Bus handshake states, one-hot.
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } t1ai_bus_t;

endpackage

/* testbench/testbench.sv */
// Self-checking bench for the receive alarm interrupt block with a behavioural model.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import t1ai_pkg::*;

   // ****************************************************************
   // Signals, counters and the behavioural model state.
   // ****************************************************************
   logic              CLK, RST, READ, WRITE, EXZ_COND, LOS_COND;   // Design inputs.
   logic              DL1_MSG_START, DL1_BYTE_STB;                 // Message pulses.
   logic [ADDR_W-1:0] ADDRESS;                                     // Byte address.
   logic [31:0]       WRITEDATA, READDATA, rd;                     // Bus data.
   logic [3:0]        BYTEENABLE;                                  // Byte enables.
   logic              WAITREQUEST, IRQ;                            // Design outputs.
   int                miscompares = 0;                             // Mismatch count.
   int                cmp_count = 0;                               // Comparison count.
   int                seed = 32'h1a78f062;                         // Random seed.
   int                flg[3];                                      // Model flags by source.
   int                en[3];                                       // Model enables, active high.
   logic [15:0]       sidx[3] = '{EXCESS_ZERO_CHANGE_FLAG_IDX, OVL_STATUS_IDX, LOS_STATUS_IDX};
   logic [15:0]       eidx[3] = '{EXZ_ENABLE_IDX, OVL_ENABLE_IDX, LOS_ENABLE_IDX};
   int                bitp[3] = '{EXZ_BIT, OVL_BIT, LOS_BIT};

   t1ai_alarm_irq i_t1ai_alarm_irq (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ),
      .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
      .WAITREQUEST(WAITREQUEST), .EXZ_COND(EXZ_COND), .LOS_COND(LOS_COND),
      .DL1_MSG_START(DL1_MSG_START), .DL1_BYTE_STB(DL1_BYTE_STB), .IRQ(IRQ));

   // The clock toggles every half period of 10 ns.
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Compares a seen value against the model value.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(posedge CLK);
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] data);
      int n;
      @(posedge CLK);
      ADDRESS    <= {idx[13:0], 2'b00};
      READ       <= ~wr;
      WRITE      <= wr;
      WRITEDATA  <= wd;
      BYTEENABLE <= be;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (WAITREQUEST !== 1'b0 && n < 20);
      // A slave that never answers ends the run.
      if (WAITREQUEST !== 1'b0) begin
         miscompares++;
         finish_test();
      end
      data = READDATA;
      READ  <= 1'b0;
      WRITE <= 1'b0;
   endtask

   task automatic rreg(input logic [15:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hf, rd);
      chk(rd, exp, "register read");
   endtask

   // Reads one status register; the model flag clears on read.
   task automatic rstat(input int s);
      rreg(sidx[s], 32'(flg[s]) << bitp[s]);
      flg[s] = 0;
   endtask

   // Writes an enable with the model following byte lane 0 and the loss inversion.
   task automatic wen(input int s, input logic [31:0] wd, input logic [3:0] be);
      bus(1'b1, eidx[s], wd, be, rd);
      if (be[0]) en[s] = (s == SRC_LOS) ? int'(!wd[bitp[s]]) : int'(wd[bitp[s]]);
   endtask

   // Checks the interrupt once flag and output latency have passed.
   task automatic chk_irq;
      int e;
      wait_c(3);
      e = 0;
      for (int s = 0; s < NUM_SRC; s++) if (flg[s] != 0 && en[s] != 0) e = 1;
      chk({31'h0, IRQ}, 32'(e), "interrupt");
   endtask

   // Checks all enable readbacks against the model.
   task automatic chk_en;
      for (int s = 0; s < NUM_SRC; s++)
         rreg(eidx[s], 32'((s == SRC_LOS) ? !en[s] : en[s]) << bitp[s]);
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      RST = 1'b1; READ = 1'b0; WRITE = 1'b0; ADDRESS = '0; WRITEDATA = '0; BYTEENABLE = '0;
      EXZ_COND = 1'b0; LOS_COND = 1'b0; DL1_MSG_START = 1'b0; DL1_BYTE_STB = 1'b0;
      flg = '{0, 0, 0};
      en = '{0, 0, 0};
      wait_c(12);
      RST <= 1'b0;
      // Reset values, plus an unmapped read and write that change nothing.
      chk_en();
      for (int s = 0; s < NUM_SRC; s++) rstat(s);
      bus(1'b1, 16'h0b12, 32'hffff_ffff, 4'hf, rd);
      rreg(16'h0b12, 32'h0);
      chk_irq();
      $display("test reset values done");
      // Both edges of each level source, with the enable off and then on.
      for (int s = 0; s < NUM_SRC; s += 2) begin
         for (int e = 0; e < 2; e++) begin
            wen(s, (s == SRC_LOS) ? 32'(!e) << LOS_BIT : 32'(e), 4'h1);
            for (int k = 0; k < 2; k++) begin
               @(posedge CLK);
               if (s == SRC_EXZ) EXZ_COND <= ~EXZ_COND;
               else LOS_COND <= ~LOS_COND;
               flg[s] = 1;
               chk_irq();
               rstat(s);
               rstat(s);
               chk_irq();
            end
         end
      end
      $display("test level change events done");
      // A change sampled at the same edge as the status read survives the read.
      fork
         begin
            @(posedge CLK);
            EXZ_COND <= ~EXZ_COND;
         end
         rstat(SRC_EXZ);
      join
      flg[SRC_EXZ] = 1;
      chk_irq();
      rstat(SRC_EXZ);
      $display("test set over clear done");
      // A 276-byte message raises nothing; the 277th byte sets the flag once.
      wen(SRC_OVL, 32'h1, 4'h1);
      @(posedge CLK);
      DL1_MSG_START <= 1'b1;
      @(posedge CLK);
      DL1_MSG_START <= 1'b0;
      DL1_BYTE_STB  <= 1'b1;
      wait_c(276);
      DL1_BYTE_STB <= 1'b0;
      chk_irq();
      rstat(SRC_OVL);
      @(posedge CLK);
      DL1_BYTE_STB <= 1'b1;
      @(posedge CLK);
      DL1_BYTE_STB <= 1'b0;
      flg[SRC_OVL] = 1;
      chk_irq();
      rstat(SRC_OVL);
      @(posedge CLK);
      DL1_BYTE_STB <= 1'b1;
      wait_c(20);
      DL1_BYTE_STB <= 1'b0;
      chk_irq();
      rstat(SRC_OVL);
      $display("test over-length message done");
      // Random enable writes with random lanes and reserved bits.
      for (int i = 0; i < 24; i++) begin
         wen(i % NUM_SRC, $random(seed), 4'($random(seed)));
         chk_en();
      end
      $display("test random enables done");
      finish_test();
   end

   // A hung run is cut short here.
   initial begin
      wait_c(60000);
      miscompares++;
      finish_test();
   end
endmodule
